// ===== rtl/mbsrv_pkg.sv
package mbsrv_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          MS_PER_S      = 1000;
  localparam int          WORDS         = 10;
  localparam int          IMG_W         = WORDS * 16;
  localparam int          MAX_CONN      = 5;
  localparam logic [15:0] STAT_WORD_BASE = 16'h0000;
  localparam logic [15:0] CMD_WORD_BASE = 16'h0400;
  localparam logic [15:0] STAT_BIT_BASE = 16'h0000;
  localparam logic [15:0] CMD_BIT_BASE  = 16'h4000;
  localparam logic [15:0] IMG_WORDS     = 16'h000A;
  localparam logic [15:0] IMG_BITS      = 16'h00A0;
  localparam logic [15:0] COIL_ON       = 16'hFF00;
  localparam logic [15:0] COIL_OFF      = 16'h0000;
  localparam logic [15:0] MAX_RD_BITS   = 16'h07D0;
  localparam logic [15:0] MAX_WR_BITS   = 16'h07B0;
  localparam logic [15:0] MAX_RD_WORDS  = 16'h007D;
  localparam logic [15:0] MAX_WR_WORDS  = 16'h007B;
  localparam logic [15:0] MAX_RW_WORDS  = 16'h0079;
  localparam logic [7:0]  FC_RD_COILS   = 8'h01;
  localparam logic [7:0]  FC_RD_DISC    = 8'h02;
  localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
  localparam logic [7:0]  FC_RD_INPUT   = 8'h04;
  localparam logic [7:0]  FC_WR_COIL    = 8'h05;
  localparam logic [7:0]  FC_WR_REG     = 8'h06;
  localparam logic [7:0]  FC_WR_COILS   = 8'h0F;
  localparam logic [7:0]  FC_WR_REGS    = 8'h10;
  localparam logic [7:0]  FC_MASK_WR    = 8'h16;
  localparam logic [7:0]  FC_RW_REGS    = 8'h17;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_FUNC      = 8'h01;
  localparam logic [7:0]  EXC_ADDR      = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  localparam int          FLASH_ON_MS   = 250;
  localparam int          FLASH_OFF_MS  = 250;
  localparam int          PAUSE_MS      = 2000;

  typedef struct packed {
    logic [2:0]       conn_id;
    logic [7:0]       func;
    logic [15:0]      rd_addr;
    logic [15:0]      rd_qty;
    logic [15:0]      wr_addr;
    logic [15:0]      wr_qty;
    logic [15:0]      and_mask;
    logic [15:0]      or_mask;
    logic [IMG_W-1:0] wdata;
  } mbsrv_req_t;

  typedef struct packed {
    logic [2:0]       conn_id;
    logic [7:0]       func;
    logic [7:0]       exc;
    logic [15:0]      count;
    logic [IMG_W-1:0] rdata;
  } mbsrv_rsp_t;

  typedef enum logic [1:0] {
    LED_DARK  = 2'b00,
    LED_ON    = 2'b01,
    LED_OFF   = 2'b10,
    LED_PAUSE = 2'b11
  } mbsrv_led_t;

  // Whole span [addr, addr+qty) lies in [base, base+lim)
  function automatic logic mbsrv_fits(input logic [15:0] addr, input logic [15:0] qty,
                                      input logic [15:0] base, input logic [15:0] lim);
    logic [16:0] top;
    top = {1'b0, addr} + {1'b0, qty};
    return (addr >= base) && (top <= ({1'b0, base} + {1'b0, lim}));
  endfunction
endpackage

// ===== rtl/mbsrv_server.sv
`timescale 1ns/1ns
module mbsrv_server #(
  parameter int TICK_CYCLES = mbsrv_pkg::CLK_HZ / mbsrv_pkg::MS_PER_S
) (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire mbsrv_pkg::mbsrv_req_t        req,
  output logic                              rsp_valid,
  input  wire logic                         rsp_ready,
  output mbsrv_pkg::mbsrv_rsp_t             rsp,
  input  wire logic [mbsrv_pkg::MAX_CONN-1:0] conn_open,
  input  wire logic [mbsrv_pkg::IMG_W-1:0]  status_in,
  output logic [mbsrv_pkg::IMG_W-1:0]       cmd_out,
  output logic                              cmd_update,
  output logic                              network_status_indicator
);
  import mbsrv_pkg::*;

  localparam int          ON_CYC   = FLASH_ON_MS;
  localparam int          OFF_CYC  = FLASH_OFF_MS;
  localparam int          PAUSE_CY = PAUSE_MS;
  localparam logic [11:0] ON_LAST  = 12'(ON_CYC - 1);
  localparam logic [11:0] OFF_LAST = 12'(OFF_CYC - 1);
  localparam logic [11:0] PAU_LAST = 12'(PAUSE_CY - 1);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request decode
  logic [IMG_W-1:0] cmd_r;
  logic [IMG_W-1:0] stat_r;
  wire  [7:0]       fc = req.func;

  wire fc_sup = (fc == FC_RD_COILS) || (fc == FC_RD_DISC) || (fc == FC_RD_HOLD)
             || (fc == FC_RD_INPUT) || (fc == FC_WR_COIL) || (fc == FC_WR_REG)
             || (fc == FC_WR_COILS) || (fc == FC_WR_REGS) || (fc == FC_MASK_WR)
             || (fc == FC_RW_REGS);
  wire is_bit_rd = (fc == FC_RD_COILS) || (fc == FC_RD_DISC);
  wire is_rd     = is_bit_rd || (fc == FC_RD_HOLD) || (fc == FC_RD_INPUT) || (fc == FC_RW_REGS);
  wire is_bit_wr = (fc == FC_WR_COIL) || (fc == FC_WR_COILS);
  wire is_one_wr = (fc == FC_WR_COIL) || (fc == FC_WR_REG) || (fc == FC_MASK_WR);
  wire is_wr     = is_bit_wr || is_one_wr || (fc == FC_WR_REGS) || (fc == FC_RW_REGS);
  wire [15:0] wr_qty = is_one_wr ? 16'h0001 : req.wr_qty;

  // Illegal value checks on counts and coil value
  wire qty_bad = (req.rd_qty == 16'h0000 && is_rd) || (wr_qty == 16'h0000 && is_wr)
    || (is_bit_rd && req.rd_qty > MAX_RD_BITS)
    || ((fc == FC_RD_HOLD || fc == FC_RD_INPUT || fc == FC_RW_REGS) && req.rd_qty > MAX_RD_WORDS)
    || (fc == FC_WR_COILS && wr_qty > MAX_WR_BITS)
    || (fc == FC_WR_REGS && wr_qty > MAX_WR_WORDS)
    || (fc == FC_RW_REGS && wr_qty > MAX_RW_WORDS)
    || (fc == FC_WR_COIL && req.wdata[15:0] != COIL_ON && req.wdata[15:0] != COIL_OFF);

  // Address windows: status zero based, commands at 16'h0400 (words) and 16'h4000 (bits)
  wire rd_in_stat = mbsrv_fits(req.rd_addr, req.rd_qty, STAT_WORD_BASE, IMG_WORDS);
  wire rd_in_cmd  = mbsrv_fits(req.rd_addr, req.rd_qty, CMD_WORD_BASE, IMG_WORDS);
  wire rd_ok =
      (fc == FC_RD_COILS) ? mbsrv_fits(req.rd_addr, req.rd_qty, CMD_BIT_BASE, IMG_BITS)
    : (fc == FC_RD_DISC)  ? mbsrv_fits(req.rd_addr, req.rd_qty, STAT_BIT_BASE, IMG_BITS)
    : (fc == FC_RD_INPUT) ? rd_in_stat
    : (rd_in_stat || rd_in_cmd);
  wire wr_ok = is_bit_wr ? mbsrv_fits(req.wr_addr, wr_qty, CMD_BIT_BASE, IMG_BITS)
                         : mbsrv_fits(req.wr_addr, wr_qty, CMD_WORD_BASE, IMG_WORDS);
  wire addr_bad = (is_rd && !rd_ok) || (is_wr && !wr_ok);

  wire [7:0] exc = !fc_sup  ? EXC_FUNC
                 : qty_bad  ? EXC_VALUE
                 : addr_bad ? EXC_ADDR
                 : EXC_NONE;
  wire exec = (exc == EXC_NONE);

  ////////////////////////////////////////////////////////////////////////
  // Read path: bits and words share one image
  wire              rd_from_cmd = (fc == FC_RD_COILS) || (!is_bit_rd && rd_in_cmd && fc != FC_RD_INPUT);
  wire [15:0]       rd_base = is_bit_rd ? ((fc == FC_RD_COILS) ? CMD_BIT_BASE : STAT_BIT_BASE)
                                        : (rd_from_cmd ? CMD_WORD_BASE : STAT_WORD_BASE);
  wire [15:0]       rd_rel  = req.rd_addr - rd_base;
  wire [15:0]       rd_off  = is_bit_rd ? rd_rel : {rd_rel[11:0], 4'h0};
  wire [15:0]       rd_nb   = is_bit_rd ? req.rd_qty : {req.rd_qty[11:0], 4'h0};
  wire [IMG_W-1:0]  rd_src  = rd_from_cmd ? cmd_r : stat_r;
  wire [IMG_W-1:0]  rd_mask = ~({IMG_W{1'b1}} << rd_nb);
  wire [IMG_W-1:0]  rd_data = (rd_src >> rd_off) & rd_mask;

  ////////////////////////////////////////////////////////////////////////
  // Write path into the command image
  wire [15:0]       wr_rel  = req.wr_addr - (is_bit_wr ? CMD_BIT_BASE : CMD_WORD_BASE);
  wire [15:0]       wr_off  = is_bit_wr ? wr_rel : {wr_rel[11:0], 4'h0};
  wire [15:0]       wr_nb   = is_bit_wr ? wr_qty : {wr_qty[11:0], 4'h0};
  wire [IMG_W-1:0]  wr_mask = (~({IMG_W{1'b1}} << wr_nb)) << wr_off;
  wire [IMG_W-1:0]  cur_sh  = cmd_r >> wr_off;
  wire [15:0]       mask_w  = (cur_sh[15:0] & req.and_mask) | (req.or_mask & ~req.and_mask);
  wire [IMG_W-1:0]  wr_src  = (fc == FC_WR_COIL) ? IMG_W'(req.wdata[15:0] == COIL_ON)
                            : (fc == FC_MASK_WR) ? IMG_W'(mask_w)
                            : req.wdata;
  wire [IMG_W-1:0]  cmd_nxt = (cmd_r & ~wr_mask) | ((wr_src << wr_off) & wr_mask);

  ////////////////////////////////////////////////////////////////////////
  // Request / answer handshake
  logic       rsp_valid_r;
  mbsrv_rsp_t rsp_r;
  logic       cmd_update_r;
  wire        take = req_valid && req_ready;
  mbsrv_rsp_t rsp_nxt;

  assign req_ready = !rsp_valid_r || rsp_ready;
  assign rsp_nxt.conn_id = req.conn_id;
  assign rsp_nxt.func    = exec ? fc : (fc | EXC_FLAG);
  assign rsp_nxt.exc     = exc;
  assign rsp_nxt.count   = (exec && is_rd) ? req.rd_qty : (exec && is_wr) ? wr_qty : 16'h0000;
  assign rsp_nxt.rdata   = (exec && is_rd) ? rd_data : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else if (take) begin
      rsp_valid_r <= 1'b1;
      rsp_r       <= rsp_nxt;
    end else if (rsp_ready) begin
      rsp_valid_r <= 1'b0;
    end
  end

  // Status image sampled each cycle; read of a combined request sees pre-write state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r       <= '0;
      cmd_r        <= '0;
      cmd_update_r <= 1'b0;
    end else begin
      stat_r       <= status_in;
      cmd_update_r <= take && exec && is_wr;
      if (take && exec && is_wr) begin
        cmd_r <= cmd_nxt;
      end
    end
  end

  assign rsp_valid  = rsp_valid_r;
  assign rsp        = rsp_r;
  assign cmd_out    = cmd_r;
  assign cmd_update = cmd_update_r;

  ////////////////////////////////////////////////////////////////////////
  // Connection count and status indicator
  logic [2:0] conn_cnt;
  always_comb begin
    conn_cnt = 3'h0;
    for (int i = 0; i < MAX_CONN; i++) begin
      conn_cnt = conn_cnt + 3'(conn_open[i]);
    end
  end

  logic [31:0] tick_cnt_r;
  wire         ms_tick = (tick_cnt_r == TICK_LAST);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= ms_tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  mbsrv_led_t led_r;
  mbsrv_led_t led_nxt;
  logic [11:0] ms_r;
  logic [11:0] ms_nxt;
  logic [2:0]  left_r;
  logic [2:0]  left_nxt;

  always_comb begin
    led_nxt  = led_r;
    ms_nxt   = ms_tick ? ms_r + 12'h001 : ms_r;
    left_nxt = left_r;
    case (led_r)
      LED_DARK: begin
        ms_nxt = 12'h000;
        if (conn_cnt != 3'h0) begin
          led_nxt  = LED_ON;
          left_nxt = conn_cnt;
        end
      end
      LED_ON: begin
        if (ms_tick && ms_r == ON_LAST) begin
          led_nxt  = (left_r == 3'h1) ? LED_PAUSE : LED_OFF;
          ms_nxt   = 12'h000;
          left_nxt = left_r - 3'h1;
        end
      end
      LED_OFF: begin
        if (ms_tick && ms_r == OFF_LAST) begin
          ms_nxt  = 12'h000;
          led_nxt = LED_ON;
        end
      end
      LED_PAUSE: begin
        if (ms_tick && ms_r == PAU_LAST) begin
          ms_nxt   = 12'h000;
          led_nxt  = (conn_cnt != 3'h0) ? LED_ON : LED_DARK;
          left_nxt = conn_cnt;
        end
      end
      default: begin
        led_nxt = LED_DARK;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_r  <= LED_DARK;
      ms_r   <= '0;
      left_r <= '0;
    end else begin
      led_r  <= led_nxt;
      ms_r   <= ms_nxt;
      left_r <= left_nxt;
    end
  end

  assign network_status_indicator = (led_r == LED_ON);
endmodule

// ===== verif/mbsrv_host.sv
`timescale 1ns/1ns
module mbsrv_host
  import mbsrv_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  req_ready,
  input  wire logic                  rsp_valid,
  input  wire mbsrv_pkg::mbsrv_rsp_t rsp,
  output logic                       req_valid,
  output mbsrv_pkg::mbsrv_req_t      req,
  output logic                       rsp_ready
);
  initial begin
    req_valid = 1'b0;
    req = '1;
    rsp_ready = 1'b1;
  end
  // One request, answer taken after an optional stall
  task automatic xfer(input mbsrv_req_t r, input int stall, output mbsrv_rsp_t a, output logic ok);
    int i;
    @(negedge sys_clk);
    req = r;
    req_valid = 1'b1;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    req = ~r;
    rsp_ready = (stall == 0);
    repeat (stall) @(negedge sys_clk);
    a = rsp;
    ok = (i < 20) && (rsp_valid === 1'b1);
    rsp_ready = 1'b1;
  endtask
endmodule

// ===== verif/mbsrv_monitor.sv
`timescale 1ns/1ns
module mbsrv_monitor
  import mbsrv_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire logic                  req_valid,
  input wire logic                  req_ready,
  input wire mbsrv_pkg::mbsrv_req_t req,
  input wire logic                  rsp_valid,
  input wire logic                  rsp_ready,
  input wire mbsrv_pkg::mbsrv_rsp_t rsp,
  input wire logic [IMG_W-1:0]      cmd_out,
  input wire logic                  cmd_update
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire taken  = req_valid && req_ready;
  wire bad_fc = !(req.func inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h16, 8'h17});
  wire is_rd  = req.func inside {FC_RD_COILS, FC_RD_DISC, FC_RD_HOLD, FC_RD_INPUT};
  a_answer_next: assert property (taken |=> rsp_valid && rsp.conn_id == $past(req.conn_id))
    else $error("answer missing one cycle after request");
  a_ready_rule: assert property (req_ready == (!rsp_valid || rsp_ready))
    else $error("ready does not follow answer handshake");
  a_rsp_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("answer changed while stalled");
  a_bad_func: assert property (taken && bad_fc |=> rsp.exc == EXC_FUNC && rsp.func == ($past(req.func) | EXC_FLAG))
    else $error("unsupported code not refused");
  a_exc_no_write: assert property (taken && bad_fc |=> !cmd_update ##1 !cmd_update)
    else $error("unsupported code wrote commands");
  a_read_no_cmd: assert property (taken && is_rd |=> !cmd_update ##1 $stable(cmd_out))
    else $error("read changed command image");
  a_cmd_on_update: assert property (!$stable(cmd_out) |-> cmd_update)
    else $error("command image changed without update pulse");
  a_exc_zero_count: assert property (rsp_valid && rsp.exc != EXC_NONE |-> rsp.count == 16'h0000 && rsp.func[7])
    else $error("exception answer malformed");
  a_word_count: assert property (rsp_valid && rsp.exc == EXC_NONE && rsp.func == FC_RD_INPUT |-> rsp.count <= IMG_WORDS)
    else $error("word read beyond image");
endmodule

// ===== verif/mbsrv_server_tb.sv
`timescale 1ns/1ns
module mbsrv_server_tb;
  import mbsrv_pkg::*;
  localparam int TICK = 4;
  logic             sys_clk, nrst, req_valid, req_ready, rsp_valid, rsp_ready, cmd_update, network_status_indicator;
  mbsrv_req_t       req;
  mbsrv_rsp_t       rsp, a;
  logic [4:0]       conn_open;
  logic [IMG_W-1:0] status_in, cmd_out;
  int               fails, num_checks;
  mbsrv_server #(.TICK_CYCLES(TICK)) u_mbsrv_server (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
    .conn_open(conn_open), .status_in(status_in), .cmd_out(cmd_out), .cmd_update(cmd_update),
    .network_status_indicator(network_status_indicator));
  mbsrv_host u_mbsrv_host (.sys_clk(sys_clk), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .req_valid(req_valid), .req(req), .rsp_ready(rsp_ready));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [IMG_W-1:0] seen, input logic [IMG_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [7:0] fc, input logic [15:0] ra, input logic [15:0] rq, input logic [15:0] wa,
                    input logic [15:0] wq, input logic [15:0] am, input logic [15:0] om,
                    input logic [IMG_W-1:0] wd, input int stall = 0);
    mbsrv_req_t r;
    logic       ok;
    r = '{conn_id:3'h2, func:fc, rd_addr:ra, rd_qty:rq, wr_addr:wa, wr_qty:wq, and_mask:am, or_mask:om, wdata:wd};
    u_mbsrv_host.xfer(r, stall, a, ok);
    check(ok, 1'b1);
    if (!ok) wrap_up();
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_words;
    op(FC_WR_REG, 0, 0, 16'h0400, 1, 0, 0, 16'h1234);
    check(cmd_out[15:0], 16'h1234);
    op(FC_WR_REGS, 0, 0, 16'h0401, 2, 0, 0, 32'hBEEF_5A5A);
    check(cmd_out[47:16], 32'hBEEF_5A5A);
    op(FC_RD_HOLD, 16'h0400, 3, 0, 0, 0, 0, 0);
    check(a.rdata, 48'hBEEF_5A5A_1234);
    check(a.count, 3);
    op(FC_WR_REG, 0, 0, 16'h0409, 1, 0, 0, 16'h00FF);
    check(cmd_out[159:144], 16'h00FF);
  endtask
  task automatic s_coils;
    op(FC_WR_COIL, 0, 0, 16'h4000, 1, 0, 0, COIL_ON);
    check(cmd_out[15:0], 16'h1235);
    op(FC_WR_COILS, 0, 0, 16'h4010, 16, 0, 0, 16'hC3A5);
    check(cmd_out[31:16], 16'hC3A5);
    op(FC_RD_COILS, 16'h4010, 16, 0, 0, 0, 0, 0);
    check(a.rdata, 16'hC3A5);
    op(FC_WR_COIL, 0, 0, 16'h4000, 1, 0, 0, COIL_OFF);
    check(cmd_out[15:0], 16'h1234);
  endtask
  task automatic s_status;
    for (int i = 0; i < WORDS; i++) status_in[16*i+:16] = 16'h0F00 | 16'(i);
    op(FC_RD_INPUT, 16'h0003, 1, 0, 0, 0, 0, 0);
    check(a.rdata, 16'h0F03);
    op(FC_RD_DISC, 16'd48, 16, 0, 0, 0, 0, 0);
    check(a.rdata, 16'h0F03);
    op(FC_RD_DISC, 16'd8, 4, 0, 0, 0, 0, 0);
    check(a.rdata, 4'hF);
    op(FC_RD_HOLD, 16'h0000, 10, 0, 0, 0, 0, 0, 3);
    check(a.rdata, status_in);
  endtask
  task automatic s_mask_rw;
    op(FC_MASK_WR, 0, 0, 16'h0400, 0, 16'hFF00, 16'h00AB, 0);
    check(cmd_out[15:0], 16'h12AB);
    op(FC_RW_REGS, 16'h0400, 1, 16'h0400, 1, 0, 0, 16'h7777);
    check(a.rdata, 16'h12AB);
    op(FC_RD_HOLD, 16'h0400, 1, 0, 0, 0, 0, 0);
    check(a.rdata, 16'h7777);
  endtask
  task automatic s_exc;
    logic [7:0] bad [6] = '{8'h00, 8'h07, 8'h08, 8'h11, 8'h18, 8'h2B};
    foreach (bad[i]) begin
      op(bad[i], 0, 1, 0, 0, 0, 0, 0);
      check(a.exc, EXC_FUNC);
      check(a.func, bad[i] | EXC_FLAG);
    end
    op(FC_RD_HOLD, 16'h040A, 1, 0, 0, 0, 0, 0);
    check(a.exc, EXC_ADDR);
    op(FC_RD_INPUT, 16'h0009, 2, 0, 0, 0, 0, 0);
    check(a.exc, EXC_ADDR);
    op(FC_WR_REG, 0, 0, 16'h0000, 1, 0, 0, 16'h5555);
    check(a.exc, EXC_ADDR);
    op(FC_RD_INPUT, 16'h0000, 0, 0, 0, 0, 0, 0);
    check(a.exc, EXC_VALUE);
    op(FC_WR_COIL, 0, 0, 16'h4000, 1, 0, 0, 16'h1234);
    check(a.exc, EXC_VALUE);
    check(cmd_out[15:0], 16'h7777);
  endtask
  task automatic s_led(input logic [4:0] open, input int want);
    int n, grp, dark, longd;
    logic prev;
    {n, grp, dark, longd, prev} = '0;
    conn_open = open;
    repeat (40000) begin
      @(negedge sys_clk);
      if (network_status_indicator && !prev) begin
        if (dark > 2 * FLASH_OFF_MS * TICK) begin
          if (n > 0) grp = n;
          if (n > 0) longd = dark;
          n = 1;
        end else begin
          n++;
        end
        dark = 0;
      end else if (!network_status_indicator) begin
        dark++;
      end
      prev = network_status_indicator;
    end
    check(grp, want);
    check(longd, PAUSE_MS * TICK);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {nrst, conn_open, status_in, fails, num_checks} = '0;
    repeat (8) @(negedge sys_clk);
    check(cmd_out, '0);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    s_words();
    s_coils();
    s_status();
    s_mask_rw();
    s_exc();
    check(network_status_indicator, 1'b0);
    s_led(5'h1F, 5);
    s_led(5'h05, 2);
    wrap_up();
  end
endmodule
bind mbsrv_server mbsrv_monitor u_mbsrv_monitor (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
  .cmd_out(cmd_out), .cmd_update(cmd_update));
